// >>> i2c_cfg_regs.svh
/*
 Constants of the I2C configuration access link: slave address, opcodes,
 controller register offsets and fields, bit timing.
 Assumes a 10 MHz system clock.
*/
`ifndef I2C_CFG_REGS_SVH
`define I2C_CFG_REGS_SVH

// link constants
`define SLV_ADDR_BASE 7'h68
`define OP_WRITE 3'h3
`define OP_READ 3'h4
`define NUM_PORTS 5'h03

// timing: a quarter of an scl period, 100 kHz bit rate
`define CLK_PERIOD_NS 100
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// controller registers, byte offsets
`define CTRL_OFS 12'h000
`define TARGET_OFS 12'h004
`define WDATA_OFS 12'h008
`define RDATA_OFS 12'h00C
`define STATUS_OFS 12'h010

// fields
`define CTRL_GO_BIT 0
`define CTRL_READ_BIT 1
`define CTRL_MERGE_BIT 2
`define TGT_PORT_LSB 0
`define TGT_BE_LSB 8
`define TGT_ADDR_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define REG_RESET 32'h0000_0000

`endif

// >>> i2c_cfg_pkg.sv
/*
 Types shared by both ends of the I2C configuration access link.
 Assumes nothing of its surroundings.
*/
package i2c_cfg_pkg;
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX = 3'b001,
        D_ACK = 3'b010,
        D_TX = 3'b011,
        D_MACK = 3'b100
    } dev_state_type;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_START = 2'b01,
        H_BIT = 2'b10,
        H_STOP = 2'b11
    } host_state_type;
endpackage : i2c_cfg_pkg

// >>> i2c_cfg_if.sv
/*
 Open-drain I2C wires between the bus master and the device.
 Each end pulls a line low by driving out 0 with its active-low enable low.
*/
`timescale 1ns/100ps
`default_nettype none
interface i2c_cfg_if;
    logic hostSclOut;
    logic hostSclOeN;
    logic hostSdaOut;
    logic hostSdaOeN;
    logic devSdaOut;
    logic devSdaOeN;
    logic scl;
    logic sda;

    // wired-and with pull-ups
    assign scl = hostSclOeN | hostSclOut;
    assign sda = (hostSdaOeN | hostSdaOut) & (devSdaOeN | devSdaOut);

    modport device (input scl, input sda, output devSdaOut, output devSdaOeN);
    modport host (input scl, input sda, output hostSclOut, output hostSclOeN,
                  output hostSdaOut, output hostSdaOeN);
endinterface : i2c_cfg_if
`default_nettype wire

// >>> i2c_cfg_device.sv
/*
 I2C slave that gives a bus master access to 32-bit per-port
 configuration registers: command packet, write data, buffered read data.
 Assumes scl and sda are synchronous to clk and much slower than it, and
 that the register side answers a request with regAck well within a bit.
*/
`timescale 1ns/100ps
`default_nettype none
`include "i2c_cfg_regs.svh"

module i2c_cfg_device
    import i2c_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // i2c link
    i2c_cfg_if.device bus,
    // address straps
    input wire logic [2:0] addrStrap,
    // register access
    output logic regReq,
    output logic regWrite,
    output logic [1:0] regPort,
    output logic [11:0] regAddr,
    output logic [3:0] regBe,
    output logic [31:0] regWdata,
    input wire logic regAck,
    input wire logic [31:0] regRdata
);
    logic sclPrev_r;
    logic sdaPrev_r;
    dev_state_type state_r;
    logic [2:0] bitCnt_r;
    logic full_r;
    logic [7:0] shift_r;
    logic [3:0] rxIdx_r;
    logic [7:0] cmd_r [4];
    logic [31:0] wdata_r;
    logic [31:0] rdBuf_r;
    logic [1:0] txIdx_r;
    logic readMode_r;
    logic [2:0] strap_r;
    logic launchRd_r;
    logic launchWr_r;
    logic sdaOeN_r;
    logic sdaOut_r;
    logic regReq_r;
    logic regWrite_r;
    logic [1:0] regPort_r;
    logic [11:0] regAddr_r;
    logic [3:0] regBe_r;

    // line events, the inputs are already synchronous
    wire logic sclRise = bus.scl & ~sclPrev_r;
    wire logic sclFall = ~bus.scl & sclPrev_r;
    wire logic startSeen = bus.scl & sclPrev_r & sdaPrev_r & ~bus.sda;
    wire logic stopSeen = bus.scl & sclPrev_r & ~sdaPrev_r & bus.sda;

    // command decode
    logic [6:0] baseAddr;
    assign baseAddr = `SLV_ADDR_BASE;
    wire logic [6:0] slaveAddr = {baseAddr[6:3], strap_r};
    wire logic [2:0] opcode = cmd_r[0][2:0];
    wire logic [4:0] portSel = {cmd_r[1][3:0], cmd_r[2][7]};
    wire logic portOk = portSel < `NUM_PORTS;
    wire logic [3:0] byteEn = cmd_r[2][5:2];
    wire logic [11:0] byteAddr = {cmd_r[2][1:0], cmd_r[3], 2'b00};

    // byte handling
    wire logic byteDone = (state_r == D_RX) & sclFall & full_r;
    wire logic addrHit = shift_r[7:1] == slaveAddr;
    wire logic byteAck = (rxIdx_r == 4'd0) ? addrHit : (rxIdx_r <= 4'd8);
    wire logic [31:0] txWord = rdBuf_r << {txIdx_r, 3'b000};
    wire logic [2:0] nextBit = bitCnt_r + 3'd1;

    assign bus.devSdaOeN = sdaOeN_r;
    assign bus.devSdaOut = sdaOut_r;
    assign regReq = regReq_r;
    assign regWrite = regWrite_r;
    assign regPort = regPort_r;
    assign regAddr = regAddr_r;
    assign regBe = regBe_r;
    assign regWdata = wdata_r;

    // straps are caught while reset is held
    always_ff @(posedge clk)
    begin
        if (srst)
            strap_r <= addrStrap;
        sdaOut_r <= 1'b0;
        sclPrev_r <= srst ? 1'b1 : bus.scl;
        sdaPrev_r <= srst ? 1'b1 : bus.sda;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= D_IDLE;
            bitCnt_r <= 3'd0;
            full_r <= 1'b0;
            shift_r <= 8'h00;
            rxIdx_r <= 4'h0;
            readMode_r <= 1'b0;
            txIdx_r <= 2'd0;
            sdaOeN_r <= 1'b1;
            launchRd_r <= 1'b0;
            launchWr_r <= 1'b0;
        end
        else
        begin
            launchRd_r <= byteDone & (rxIdx_r == 4'd4);
            launchWr_r <= byteDone & (rxIdx_r == 4'd8);
            if (startSeen)
            begin
                // a repeated start keeps the command and buffer
                state_r <= D_RX;
                rxIdx_r <= 4'h0;
                bitCnt_r <= 3'd0;
                full_r <= 1'b0;
                sdaOeN_r <= 1'b1;
            end
            else if (stopSeen)
            begin
                state_r <= D_IDLE;
                sdaOeN_r <= 1'b1;
            end
            else
            begin
                unique case (state_r)
                    D_IDLE: ;
                    D_RX:
                    begin
                        if (sclRise)
                        begin
                            shift_r <= {shift_r[6:0], bus.sda};
                            bitCnt_r <= nextBit;
                            full_r <= bitCnt_r == 3'd7;
                        end
                        else if (byteDone)
                        begin
                            full_r <= 1'b0;
                            state_r <= byteAck ? D_ACK : D_IDLE;
                            sdaOeN_r <= ~byteAck;
                            if (rxIdx_r == 4'd0)
                            begin
                                readMode_r <= shift_r[0];
                                txIdx_r <= 2'd0;
                                rxIdx_r <= shift_r[0] ? 4'd0 : 4'd1;
                            end
                            else
                                rxIdx_r <= rxIdx_r + 4'd1;
                        end
                    end
                    D_ACK:
                    begin
                        if (sclFall)
                        begin
                            bitCnt_r <= 3'd0;
                            state_r <= readMode_r ? D_TX : D_RX;
                            sdaOeN_r <= readMode_r ? txWord[31] : 1'b1;
                        end
                    end
                    D_TX:
                    begin
                        if (sclFall)
                        begin
                            bitCnt_r <= nextBit;
                            state_r <= (bitCnt_r == 3'd7) ? D_MACK : D_TX;
                            sdaOeN_r <= (bitCnt_r == 3'd7) ? 1'b1 :
                                txWord[5'd31 - {2'b00, nextBit}];
                        end
                    end
                    D_MACK:
                    begin
                        if (sclRise)
                        begin
                            if (bus.sda)
                                state_r <= D_IDLE;
                            else
                                txIdx_r <= txIdx_r + 2'd1;
                        end
                        else if (sclFall)
                        begin
                            state_r <= D_TX;
                            bitCnt_r <= 3'd0;
                            sdaOeN_r <= txWord[31];
                        end
                    end
                    default: state_r <= D_IDLE;
                endcase
            end
        end
    end

    // command and write data capture
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < 4; i++)
                cmd_r[i] <= 8'h00;
            wdata_r <= `REG_RESET;
        end
        else if (byteDone && rxIdx_r >= 4'd1 && rxIdx_r <= 4'd4)
            cmd_r[rxIdx_r[1:0] - 2'd1] <= shift_r;
        else if (byteDone && rxIdx_r >= 4'd5 && rxIdx_r <= 4'd8)
            wdata_r <= {wdata_r[23:0], shift_r};
    end

    // register request, held until acknowledged
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            regReq_r <= 1'b0;
            regWrite_r <= 1'b0;
            regPort_r <= 2'd0;
            regAddr_r <= 12'h000;
            regBe_r <= 4'h0;
            rdBuf_r <= `REG_RESET;
        end
        else if (regReq_r)
        begin
            if (regAck)
            begin
                regReq_r <= 1'b0;
                if (!regWrite_r)
                    rdBuf_r <= regRdata;
            end
        end
        else if (portOk && ((launchRd_r && opcode == `OP_READ) ||
                            (launchWr_r && opcode == `OP_WRITE)))
        begin
            regReq_r <= 1'b1;
            regWrite_r <= launchWr_r;
            regPort_r <= portSel[1:0];
            regAddr_r <= byteAddr;
            regBe_r <= byteEn;
        end
    end
endmodule : i2c_cfg_device
`default_nettype wire

// >>> i2c_cfg_host.sv
/*
 I2C bus master that carries out one register read or write on the
 configuration link per software order, given over an APB slave.
 Assumes the device answers on the same wires and does not stretch scl.
*/
`timescale 1ns/100ps
`default_nettype none
`include "i2c_cfg_regs.svh"

module i2c_cfg_host
    import i2c_cfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `SLV_ADDR_BASE,
    parameter int QUARTER_CYC = `SCL_QUARTER_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // i2c link
    i2c_cfg_if.host bus
);
    host_state_type state_r;
    logic [15:0] qCnt_r;
    logic [1:0] ph_r;
    logic [3:0] step_r;
    logic [3:0] bit_r;
    logic nackSmp_r;
    logic abort_r;
    logic readMode_r;
    logic merge_r;
    logic [31:0] target_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic busy_r;
    logic nack_r;
    logic sclOeN_r;
    logic sdaOeN_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // apb decode
    wire logic setup = psel & ~penable;
    wire logic wrAcc = psel & penable & pready_r & pwrite;
    wire logic mapped = paddr == `CTRL_OFS || paddr == `TARGET_OFS ||
        paddr == `WDATA_OFS || paddr == `RDATA_OFS || paddr == `STATUS_OFS;
    wire logic go = wrAcc & (paddr == `CTRL_OFS) & pwdata[`CTRL_GO_BIT] & ~busy_r;
    wire logic [31:0] readMux =
        (paddr == `CTRL_OFS) ? {29'h0, merge_r, readMode_r, busy_r} :
        (paddr == `TARGET_OFS) ? target_r :
        (paddr == `WDATA_OFS) ? wdata_r :
        (paddr == `RDATA_OFS) ? rdata_r :
        (paddr == `STATUS_OFS) ? {30'h0, nack_r, busy_r} : `REG_RESET;

    // command fields
    wire logic [4:0] port = target_r[`TGT_PORT_LSB +: 5];
    wire logic [3:0] be = target_r[`TGT_BE_LSB +: 4];
    wire logic [11:0] addr = target_r[`TGT_ADDR_LSB +: 12];
    wire logic [3:0] lastStep = readMode_r ? 4'd9 : 4'd8;
    wire logic rxStep = readMode_r & (step_r >= 4'd6);
    wire logic tick = qCnt_r == 16'(QUARTER_CYC - 1);
    logic [7:0] txByte;

    always_comb
    begin
        unique case (step_r)
            4'd0: txByte = {SLAVE_ADDR, 1'b0};
            4'd1: txByte = {5'h00, readMode_r ? `OP_READ : `OP_WRITE};
            4'd2: txByte = {4'h0, port[4:1]};
            4'd3: txByte = {port[0], 1'b0, be, addr[11:10]};
            4'd4: txByte = addr[9:2];
            4'd5: txByte = readMode_r ? {SLAVE_ADDR, 1'b1} : wdata_r[31:24];
            4'd6: txByte = wdata_r[23:16];
            4'd7: txByte = wdata_r[15:8];
            default: txByte = wdata_r[7:0];
        endcase
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bus.hostSclOeN = sclOeN_r;
    assign bus.hostSdaOeN = sdaOeN_r;
    assign bus.hostSclOut = 1'b0;
    assign bus.hostSdaOut = 1'b0;

    // zero wait states: ready in every access phase
    always_ff @(posedge clk)
    begin
        pready_r <= ~srst & setup;
        pslverr_r <= ~srst & setup & ~mapped;
        prdata_r <= srst ? `REG_RESET : (setup ? readMux : prdata_r);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            target_r <= `REG_RESET;
            wdata_r <= `REG_RESET;
            readMode_r <= 1'b0;
            merge_r <= 1'b0;
        end
        else if (wrAcc && !busy_r)
        begin
            if (paddr == `CTRL_OFS)
            begin
                readMode_r <= pwdata[`CTRL_READ_BIT];
                merge_r <= pwdata[`CTRL_MERGE_BIT];
            end
            if (paddr == `TARGET_OFS)
                target_r <= pwdata;
            if (paddr == `WDATA_OFS)
                wdata_r <= pwdata;
        end
    end

    // bit engine, four quarter phases per bit
    always_ff @(posedge clk)
    begin
        if (srst || state_r == H_IDLE)
            qCnt_r <= 16'h0000;
        else
            qCnt_r <= tick ? 16'h0000 : qCnt_r + 16'h0001;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= H_IDLE;
            ph_r <= 2'd0;
            step_r <= 4'h0;
            bit_r <= 4'h0;
            nackSmp_r <= 1'b0;
            abort_r <= 1'b0;
            busy_r <= 1'b0;
            nack_r <= 1'b0;
            rdata_r <= `REG_RESET;
            sclOeN_r <= 1'b1;
            sdaOeN_r <= 1'b1;
        end
        else if (state_r == H_IDLE)
        begin
            ph_r <= 2'd0;
            if (go)
            begin
                state_r <= H_START;
                step_r <= 4'h0;
                abort_r <= 1'b0;
                busy_r <= 1'b1;
                nack_r <= 1'b0;
            end
        end
        else if (tick)
        begin
            ph_r <= ph_r + 2'd1;
            unique case (state_r)
                H_START:
                begin
                    sdaOeN_r <= (ph_r >= 2'd2) ? 1'b0 : 1'b1;
                    sclOeN_r <= (ph_r == 2'd3) ? 1'b0 : 1'b1;
                    bit_r <= 4'h0;
                    if (ph_r == 2'd3)
                        state_r <= H_BIT;
                end
                H_BIT:
                begin
                    unique case (ph_r)
                        2'd0:
                        begin
                            if (bit_r < 4'd8)
                                sdaOeN_r <= rxStep | txByte[3'd7 - bit_r[2:0]];
                            else
                                sdaOeN_r <= ~rxStep | (step_r == lastStep);
                        end
                        2'd1: sclOeN_r <= 1'b1;
                        2'd2:
                        begin
                            nackSmp_r <= bus.sda;
                            if (rxStep && bit_r < 4'd8)
                                rdata_r <= {rdata_r[30:0], bus.sda};
                        end
                        default:
                        begin
                            sclOeN_r <= 1'b0;
                            bit_r <= (bit_r == 4'd8) ? 4'h0 : bit_r + 4'h1;
                            if (bit_r == 4'd8)
                            begin
                                step_r <= step_r + 4'h1;
                                if (!rxStep && nackSmp_r)
                                begin
                                    abort_r <= 1'b1;
                                    nack_r <= 1'b1;
                                    state_r <= H_STOP;
                                end
                                else if (step_r == lastStep)
                                    state_r <= H_STOP;
                                else if (readMode_r && step_r == 4'd4)
                                    state_r <= merge_r ? H_START : H_STOP;
                            end
                        end
                    endcase
                end
                default:
                begin
                    sdaOeN_r <= ph_r >= 2'd2;
                    sclOeN_r <= ph_r != 2'd0;
                    if (ph_r == 2'd3)
                    begin
                        // a separate read packet follows the command packet
                        if (!abort_r && readMode_r && step_r == 4'd5)
                            state_r <= H_START;
                        else
                        begin
                            state_r <= H_IDLE;
                            busy_r <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end
endmodule : i2c_cfg_host
`default_nettype wire

// >>> i2c_cfg_asserts.sv
/*
 Checker on the wires between the bus master and the device.
 Assumes scl and sda are sampled on clk and the straps held during a run.
*/
`timescale 1ns/100ps
`default_nettype none
module i2c_cfg_asserts #(
    parameter int QUARTER_CYC = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic hostSclOeN,
    input wire logic hostSdaOeN,
    input wire logic devSdaOeN,
    // straps
    input wire logic [2:0] addrStrap
);
    // a byte and its ack slot, with margin
    localparam int LOW_MAX = 40 * QUARTER_CYC;
    logic sclQ_r;
    logic sdaQ_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r;
    logic firstByte_r;
    logic dirRead_r;
    // a master nak ends the read: the stop after it is the master's own
    logic lastNak_r;
    wire sclRise = scl & ~sclQ_r;
    wire startCond = scl & sclQ_r & sdaQ_r & ~sda;
    wire ackRise = sclRise & (bitCnt_r == 4'h8);
    wire addrMatch = (shift_r[7:1] == {4'hD, addrStrap});
    // the rising cycle is left out: bit count lags scl by one clock
    wire dataHigh = scl & sclQ_r & (bitCnt_r != 4'h0) & (bitCnt_r != 4'h8);

    always_ff @(posedge clk)
    begin
        sclQ_r <= scl;
        sdaQ_r <= sda;
    end

    always_ff @(posedge clk)
    begin
        if (srst | startCond)
        begin
            bitCnt_r <= 4'h0;
            firstByte_r <= 1'b1;
            lastNak_r <= 1'b0;
        end
        else if (ackRise)
        begin
            bitCnt_r <= 4'h0;
            firstByte_r <= 1'b0;
            lastNak_r <= sda;
            dirRead_r <= firstByte_r ? shift_r[0] : dirRead_r;
        end
        else if (sclRise)
        begin
            bitCnt_r <= bitCnt_r + 4'h1;
            shift_r <= {shift_r[6:0], sda};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_ADDR_ACK: assert property (ackRise && firstByte_r && addrMatch |-> !sda)
        else $error("matching address not acknowledged");
    AST_ADDR_NAK: assert property (ackRise && firstByte_r && !addrMatch |-> devSdaOeN)
        else $error("foreign address acknowledged");
    AST_ADDR_QUIET: assert property (firstByte_r && dataHigh |-> devSdaOeN)
        else $error("device drives during address byte");
    AST_WRITE_QUIET: assert property (!firstByte_r && !dirRead_r && dataHigh |-> devSdaOeN)
        else $error("device drives data in a write transfer");
    AST_READ_HOST_FREE: assert property (!firstByte_r && dirRead_r && !lastNak_r && dataHigh |-> hostSdaOeN)
        else $error("master drives data in a read transfer");
    AST_DEV_STABLE: assert property (scl && sclQ_r |-> $stable(devSdaOeN))
        else $error("device sda changes while scl high");
    AST_DEV_LOW_BOUND: assert property ($fell(devSdaOeN) |-> ##[1:LOW_MAX] devSdaOeN)
        else $error("device holds sda low too long");
    AST_RESET_IDLE: assert property ($fell(srst) |-> hostSclOeN && hostSdaOeN && devSdaOeN)
        else $error("lines not released after reset");

    cover property (ackRise && firstByte_r && addrMatch && shift_r[0]);
    cover property (ackRise && firstByte_r && addrMatch && !shift_r[0]);
    cover property (ackRise && firstByte_r && !addrMatch);
endmodule : i2c_cfg_asserts
`default_nettype wire

// >>> tb.sv
/*
 Bench: master and device joined by the link, APB driver, register model.
 Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "i2c_cfg_regs.svh"
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] addrStrap = 3'h0;
    logic regReq;
    logic regWrite;
    logic [1:0] regPort;
    logic [11:0] regAddr;
    logic [3:0] regBe;
    logic [31:0] regWdata;
    logic regAck = 1'b0;
    logic [31:0] regRdata = 32'h0000_0000;
    logic [31:0] mem [0:4095];
    logic [31:0] rd;
    logic [31:0] st;
    logic err;
    int badCount = 0;
    int testsRun = 0;
    int reqCount = 0;
    int prevReq;

    always #50 clk = ~clk;

    i2c_cfg_if link();
    i2c_cfg_host #(.QUARTER_CYC(4)) i2c_cfg_host_inst (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(link.host));
    i2c_cfg_device i2c_cfg_device_inst (.clk(clk), .srst(srst), .bus(link.device),
        .addrStrap(addrStrap), .regReq(regReq), .regWrite(regWrite), .regPort(regPort),
        .regAddr(regAddr), .regBe(regBe), .regWdata(regWdata), .regAck(regAck),
        .regRdata(regRdata));
    i2c_cfg_asserts #(.QUARTER_CYC(4)) i2c_cfg_asserts_inst (.clk(clk), .srst(srst),
        .scl(link.scl), .sda(link.sda), .hostSclOeN(link.hostSclOeN),
        .hostSdaOeN(link.hostSdaOeN), .devSdaOeN(link.devSdaOeN), .addrStrap(addrStrap));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            badCount++;
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // register side: answers one cycle after a request, byte enables honoured
    always @(posedge clk)
    begin
        regAck <= 1'b0;
        if (regReq === 1'b1 && !regAck)
        begin
            regAck <= 1'b1;
            reqCount <= reqCount + 1;
            check({30'h0, regAddr[1:0]}, 32'h0);
            for (int b = 0; b < 4; b++)
                if (regWrite && regBe[b])
                    mem[{regPort, regAddr[11:2]}][8*b+:8] = regWdata[8*b+:8];
            regRdata <= mem[{regPort, regAddr[11:2]}];
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // the answer is taken at the edge that samples pready high
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 50)
        begin
            badCount++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one link transfer: ctl bit0 go, bit1 read, bit2 merged read
    task automatic op(input logic [2:0] ctl, input logic [4:0] port, input logic [3:0] be,
        input logic [11:0] a, input logic [31:0] d);
        int n;
        apb(1'b1, `TARGET_OFS, {4'h0, a, 4'h0, be, 3'h0, port});
        apb(1'b1, `WDATA_OFS, d);
        apb(1'b1, `CTRL_OFS, {29'h0, ctl});
        for (n = 0; n < 1000; n++)
        begin
            apb(1'b0, `STATUS_OFS, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        if (n == 1000)
        begin
            badCount++;
            print_verdict();
        end
        st = rd;
        apb(1'b0, `RDATA_OFS, 32'h0);
    endtask : op

    task automatic resetWith(input logic [2:0] strap);
        @(posedge clk);
        srst <= 1'b1;
        addrStrap <= strap;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
    endtask : resetWith

    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 32'h0000_0000;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, `STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset and unmapped done");
        for (int p = 0; p < 3; p++)
        begin
            op(3'h1, 5'(p), 4'hF, 12'h3F8 + 12'(p) * 12'h400, 32'h1234_5678 + p);
            check({30'h0, st[1:0]}, 32'h0);
            check(mem[{p[1:0], p[1:0], 8'hFE}], 32'h1234_5678 + p);
        end
        $display("test full writes on every port done");
        op(3'h1, 5'h00, 4'h5, 12'hFFC, 32'hAABB_CCDD);
        check(mem[12'h3FF], 32'h00BB_00DD);
        op(3'h1, 5'h00, 4'hA, 12'hFFC, 32'h1122_3344);
        check(mem[12'h3FF], 32'h11BB_33DD);
        $display("test byte enables done");
        op(3'h3, 5'h00, 4'hF, 12'hFFC, 32'h0);
        check(rd, 32'h11BB_33DD);
        op(3'h3, 5'h01, 4'hF, 12'h7F8, 32'h0);
        check(rd, 32'h1234_5679);
        op(3'h7, 5'h02, 4'hF, 12'hBF8, 32'h0);
        check(rd, 32'h1234_567A);
        $display("test two-packet and merged reads done");
        prevReq = reqCount;
        op(3'h1, 5'h03, 4'hF, 12'h000, 32'hDEAD_BEEF);
        op(3'h1, 5'h10, 4'hF, 12'h000, 32'hDEAD_BEEF);
        check(reqCount, prevReq);
        check({30'h0, st[1:0]}, 32'h0);
        $display("test unsupported ports done");
        resetWith(3'h1);
        op(3'h1, 5'h00, 4'hF, 12'h000, 32'hDEAD_BEEF);
        check({30'h0, st[1:0]}, 32'h2);
        check(reqCount, prevReq);
        resetWith(3'h0);
        op(3'h3, 5'h00, 4'hF, 12'hFFC, 32'h0);
        check(rd, 32'h11BB_33DD);
        $display("test address straps done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
